// ### bench/testbench.sv
// Register-level testbench of the watchdog timer.
`timescale 1ns/1ps
module testbench;
	import wdt_pkg::*;
	logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack, wrst, irq;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0, rdat;
	int failures = 0, checked = 0;
	always #12.5 clk = ~clk;
	watchdog_interval_timer #(.pulse_len(2)) dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wdt_reset_o(wrst), .irq_o(irq));
	////////////////////////////////////////////////////////////////
	task ck(input string nm, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : ck
	task wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
		int n;
		@(posedge clk);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
		n = 0;
		do @(posedge clk); while (ack !== 1'b1 && n++ < 64);
		if (ack !== 1'b1) failures++;
		if (!w) ck($sformatf("reg %h", a), e, rdat[7:0]);
		{cyc, stb} <= 2'b00;
	endtask : wb
	task wait_out(input int which);
		for (int n = 0; n < 3000 && (which ? wrst : irq) !== 1'b1; n++) @(posedge clk);
		ck(which ? "reset out" : "irq", 8'h01, {7'h0, which ? wrst : irq});
	endtask : wait_out
	task wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		#500000;
		failures++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		wb(0, ctrl_addr, 0, ctrl_reset);
		wb(0, 4'h2, 0, 8'h00);
		wb(1, irq_mask_addr, 8'h01, 0);
		wb(1, ctrl_addr, 8'h20, 0);
		wait_out(0);
		wb(1, ctrl_addr, 8'h20, 0);
		wb(0, ctrl_addr, 0, 8'hb8);
		wb(1, ctrl_addr, 8'ha0, 0);
		wb(0, ctrl_addr, 0, 8'hb8);
		wb(1, ctrl_addr, 8'h20, 0);
		wb(0, ctrl_addr, 0, 8'h38);
		wb(1, irq_stat_addr, 8'h01, 0);
		wb(1, ctrl_addr, 8'h00, 0);
		ck("irq", 8'h00, {7'h0, irq});
		wb(0, count_addr, 0, 8'h00);
		wb(0, rst_stat_addr, 0, 8'h7f);
		wb(1, ctrl_addr, 8'h60, 0);
		wait_out(1);
		wb(1, ctrl_addr, 8'h00, 0);
		wb(0, rst_stat_addr, 0, 8'hff);
		wb(1, rst_stat_addr, 8'hff, 0);
		wb(0, rst_stat_addr, 0, 8'hff);
		wb(1, rst_stat_addr, 8'h7f, 0);
		wb(0, rst_stat_addr, 0, 8'h7f);
		wrap_up();
	end
endmodule : testbench

// ### bench/wdt_chk.sv
// Checker for bus timing and the reset pulse of the watchdog timer.
`timescale 1ns/1ps
module wdt_chk #(
	parameter int pulse_len = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wdt_reset_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	int hi_q;
	// Counts high cycles, so the pulse length is judged exactly without long repetitions.
	always_ff @(posedge clk) hi_q <= (reset || !wdt_reset_o) ? 0 : hi_q + 1;
	sequence req_s;
		wb_cyc_i && wb_stb_i;
	endsequence
	a_ack_follows: assert property (req_s ##0 !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_pulse_length: assert property ($fell(wdt_reset_o) |-> hi_q == pulse_len)
		else $error("reset pulse length");
	a_pulse_bound: assert property (wdt_reset_o |-> hi_q < pulse_len)
		else $error("reset pulse too long");
	a_pulse_min: assert property ($rose(wdt_reset_o) |=> wdt_reset_o)
		else $error("reset pulse short");
endmodule : wdt_chk
////////////////////////////////////////////////////////////////
bind watchdog_interval_timer wdt_chk #(.pulse_len(pulse_len)) chk_u (.clk(clk), .reset(reset),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wdt_reset_o(wdt_reset_o));

// ### core/watchdog_interval_timer.sv
// Watchdog and interval timer with a classic Wishbone register slave.
`timescale 1ns/1ps

module watchdog_interval_timer
	import wdt_pkg::*;
#(
	parameter int pulse_len = reset_pulse_cycles
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wdt_reset_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	logic [7:0] ctrl_q;
	logic [7:0] up_counter_q;
	logic [prescale_width-1:0] pre_q;
	logic wrap_armed_q;
	logic rst_flag_q;
	logic rst_armed_q;
	logic [7:0] pulse_q;
	logic irq_stat_q;
	logic irq_mask_q;
	logic ack_q;
	logic [31:0] rdata_q;

	wire req = wb_cyc_i && wb_stb_i && !ack_q;
	wire wr = req && wb_we_i && wb_sel_i[0];
	wire rd = req && !wb_we_i;
	wire sel_ctrl = wb_adr_i == ctrl_addr;
	wire sel_cnt = wb_adr_i == count_addr;
	wire sel_rst = wb_adr_i == rst_stat_addr;
	wire sel_irq = wb_adr_i == irq_stat_addr;
	wire sel_mask = wb_adr_i == irq_mask_addr;
	wire timer_run_enable = ctrl_q[run_bit];
	wire timer_mode_select = ctrl_q[mode_bit];
	wire wrap_flag = ctrl_q[wrap_flag_bit];
	wire [2:0] cks = ctrl_q[2:0];

	// Divide ratios 2,32,64,128,256,512,2048,4096 as the prescaler bit that toggles.
	logic [3:0] tap;
	always_comb begin
		case (cks)
			3'h0: tap = 4'h0;
			3'h1: tap = 4'h4;
			3'h2: tap = 4'h5;
			3'h3: tap = 4'h6;
			3'h4: tap = 4'h7;
			3'h5: tap = 4'h8;
			3'h6: tap = 4'ha;
			default: tap = 4'hb;
		endcase
	end
	wire [prescale_width-1:0] pre_next = pre_q + 1'b1;
	wire tick = timer_run_enable && pre_q[tap] && !pre_next[tap];
	wire wrap = tick && up_counter_q == 8'hff;
	wire wd_fire = wrap && timer_mode_select;

	// Wrap and reset flag clears only take effect once the flag was read as one.
	wire clr_wrap = wr && sel_ctrl && !wb_dat_i[wrap_flag_bit] && wrap_armed_q;
	wire clr_rst = wr && sel_rst && !wb_dat_i[rst_flag_bit] && rst_armed_q;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (reset || !timer_run_enable) begin
			up_counter_q <= 8'h00;
			pre_q <= '0;
		end else begin
			pre_q <= pre_next;
			if (tick) up_counter_q <= up_counter_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q <= ctrl_reset;
		end else begin
			if (wr && sel_ctrl) begin
				ctrl_q[6:5] <= wb_dat_i[6:5];
				ctrl_q[2:0] <= wb_dat_i[2:0];
			end
			if (wrap) ctrl_q[wrap_flag_bit] <= 1'b1;
			else if (clr_wrap) ctrl_q[wrap_flag_bit] <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wrap_armed_q <= 1'b0;
			rst_armed_q <= 1'b0;
		end else begin
			if (rd && sel_ctrl && wrap_flag) wrap_armed_q <= 1'b1;
			else if (clr_wrap || (wr && sel_ctrl)) wrap_armed_q <= 1'b0;
			if (rd && sel_rst && rst_flag_q) rst_armed_q <= 1'b1;
			else if (wr && sel_rst) rst_armed_q <= 1'b0;
		end
	end

	// The reset flag survives the pulse it reports, so software can see why it restarted.
	always_ff @(posedge clk) begin
		if (reset) begin
			rst_flag_q <= 1'b0;
			pulse_q <= 8'h00;
		end else begin
			if (wd_fire) rst_flag_q <= 1'b1;
			else if (clr_rst) rst_flag_q <= 1'b0;
			if (wd_fire) pulse_q <= 8'(pulse_len);
			else if (pulse_q != 8'h00) pulse_q <= pulse_q - 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_stat_q <= 1'b0;
			irq_mask_q <= 1'b0;
		end else begin
			if (wrap && !timer_mode_select) irq_stat_q <= 1'b1;
			else if (wr && sel_irq && wb_dat_i[0]) irq_stat_q <= 1'b0;
			if (wr && sel_mask) irq_mask_q <= wb_dat_i[0];
		end
	end

	wire [31:0] rmux = sel_ctrl ? {24'h0, ctrl_q | ctrl_fixed_ones} :
		sel_cnt ? {24'h0, up_counter_q} :
		sel_rst ? {24'h0, rst_flag_q, 7'h7f} :
		sel_irq ? {31'h0, irq_stat_q} :
		sel_mask ? {31'h0, irq_mask_q} : 32'h0;

	always_ff @(posedge clk) begin
		if (reset) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ack_q <= req;
			rdata_q <= rmux;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;
	assign wdt_reset_o = pulse_q != 8'h00;
	assign irq_o = irq_stat_q && irq_mask_q;

endmodule : watchdog_interval_timer

// ### core/wdt_pkg.sv
// Package with register map, field positions, reset values and timing constants of the watchdog.
package wdt_pkg;

	// Register byte addresses on the Wishbone bus.
	localparam logic [3:0] ctrl_addr = 4'h0;
	localparam logic [3:0] count_addr = 4'h4;
	localparam logic [3:0] rst_stat_addr = 4'h8;
	localparam logic [3:0] irq_stat_addr = 4'hc;
	localparam logic [3:0] irq_mask_addr = 4'h1;

	// Control/status field positions.
	localparam int wrap_flag_bit = 7;
	localparam int mode_bit = 6;
	localparam int run_bit = 5;
	localparam int rst_flag_bit = 7;

	// Reset values: bits 4 and 3 of the control register read as one.
	localparam logic [7:0] ctrl_fixed_ones = 8'h18;
	localparam logic [7:0] ctrl_reset = 8'h18;

	// Duration of the watchdog reset pulse, in system clock cycles.
	localparam int reset_pulse_cycles = 16;

	// Prescaler width, enough for the slowest divide ratio of 4096.
	localparam int prescale_width = 12;

endpackage : wdt_pkg
